// ===== pdh_pkg.sv
// pdh_pkg: constants, register map and field layout for the loop configuration bank.
// assumes: one 50 MHz clock; the three-wire port pins are synchronous to it.
//
// Summary of operation
// - with rail detect on, tuning code near the supply rail enters holdover.
// - with rail detect on, tuning code near ground enters holdover.
// - bit 5 of trip register makes a reached trip point count as loop1 unlock.
// - override dac code field takes written value; reads return present dac code.
// - override enable bit selects manual dac code; resets to automatic.
// - holdover is left only after lock holds for the exit count of loop1 ticks.
// - loop1 lock window field selects phase window; resets to 3, 40 ns.
// - dac update rate is loop1 detector rate divided by the divisor field.
// - loop1 lock asserts only after lock holds for the loop1 lock count.
// - loop2 reference doubler bit doubles loop2 reference; resets to off.
// - loop2 lock asserts after phase stays in window for loop2 lock count.
// - loop2 pump polarity, gain and tristate fields with their reset values.
// - loop1 pump polarity, gain and tristate fields with their reset values.
// - each input clock has a 2-bit pre-divider, reset divide by one.
// - loop1 reference divider, 14 bits, reset 96.
// - loop2 reference divider, 12 bits, reset 4.
// - loop1 feedback divider, 14 bits, reset 192.
// - fast detector bit permits loop2 detector above 100 MHz; resets set.
// - loop2 calibration divider, 18 bits, reset 48.
// - loop2 prescaler, 3 bits, divides 2 to 8, reset 2.
// - loop2 feedback divider, 18 bits, reset 48.
package pdh_pkg;

  localparam int NREG = 10;

  // ****************************************
  // register addresses (5-bit field in bits 4:0 of each frame)
  // ****************************************
  localparam logic [4:0] A_DAC_TRIP   = 5'h0E;
  localparam logic [4:0] A_OVERRIDE_DAC_CODE    = 5'h0F;
  localparam logic [4:0] A_XTAL       = 5'h10;
  localparam logic [4:0] A_LF_DLY     = 5'h18;
  localparam logic [4:0] A_DAC_CLK    = 5'h19;
  localparam logic [4:0] A_LOOP2_CTL  = 5'h1A;
  localparam logic [4:0] A_LOOP1_CTL  = 5'h1B;
  localparam logic [4:0] A_DIVIDERS   = 5'h1C;
  localparam logic [4:0] A_OSC_CAL    = 5'h1D;
  localparam logic [4:0] A_LOOP2_FB   = 5'h1E;

  // ****************************************
  // reset values of whole registers
  // ****************************************
  localparam logic [31:0] RST_DAC_TRIP  = 32'h0000_0000;
  localparam logic [31:0] RST_OVERRIDE_DAC_CODE   = 32'h8000_8000;
  localparam logic [31:0] RST_XTAL      = 32'h0000_0000;
  localparam logic [31:0] RST_LF_DLY    = 32'h0000_00C0;
  localparam logic [31:0] RST_DAC_CLK   = 32'h0101_0000;
  localparam logic [31:0] RST_LOOP2_CTL = 32'h0C08_0000;
  localparam logic [31:0] RST_LOOP1_CTL = 32'h1000_1800;
  localparam logic [31:0] RST_DIVIDERS  = 32'h0040_3000;
  localparam logic [31:0] RST_OSC_CAL   = 32'h0780_0600;
  localparam logic [31:0] RST_LOOP2_FB  = 32'h0200_0600;

  // ****************************************
  // field positions (lsb); F_TOP10, F_CNT14, F_BIT5 and F_N18 shared by several registers
  // ****************************************
  localparam int F_TOP10 = 22;
  localparam int F_CNT14 = 6;
  localparam int F_HTRIP = 14;
  localparam int F_LTRIP = 6;
  localparam int F_BIT5  = 5;
  localparam int F_OVR   = 20;
  localparam int F_N18   = 5;
  localparam int TRIP_SHIFT = 4;
  localparam logic [9:0] DAC_RST = 10'h200;

  typedef struct packed {
    logic [1:0]  loop1_lock_window;
    logic [1:0]  loop2_lock_window;
    logic        loop2_ref_doubler;
    logic        loop2_pump_polarity;
    logic [1:0]  loop2_pump_gain;
    logic        loop2_pump_tristate;
    logic        loop1_pump_polarity;
    logic [1:0]  loop1_pump_gain;
    logic        loop1_pump_tristate;
    logic [1:0]  input1_prediv;
    logic [1:0]  input0_prediv;
    logic [13:0] loop1_ref_divider;
    logic [11:0] loop2_ref_divider;
    logic [13:0] loop1_feedback_divider;
    logic [2:0]  osc_input_range;
    logic        loop2_fast_detector;
    logic [17:0] loop2_cal_divider;
    logic [2:0]  loop2_prescaler;
    logic [17:0] loop2_feedback_divider;
  } pdh_cfg_s;

  typedef enum logic [0:0] {ST_TRACK, ST_HOLD} pdh_mode_e;

endpackage

// ===== pdh_bank.sv
// pdh_bank: three-wire configured register bank with lock detect, holdover and dac control.
// assumes: pd1_tick and pd2_tick are one-cycle pulses per phase detector cycle, synchronous.
`timescale 1ns/10ps
module pdh_bank (
  input  wire logic               mclk,
  input  wire logic               nrst,
  input  wire logic               uw_clk,
  input  wire logic               uw_data,
  input  wire logic               uw_le,
  input  wire logic               pd1_tick,
  input  wire logic               pd2_tick,
  input  wire logic               loop1_in_window,
  input  wire logic               loop2_in_window,
  input  wire logic [9:0]         vtune_code,
  output logic                    uw_readback,
  output logic                    holdover,
  output logic                    loop1_lock,
  output logic                    loop2_lock,
  output logic [9:0]              dac_code,
  output pdh_pkg::pdh_cfg_s       cfg
);

  // ****************************************
  // register storage
  // ****************************************
  localparam logic [4:0]  ADDR_TAB [pdh_pkg::NREG] = '{
    pdh_pkg::A_DAC_TRIP, pdh_pkg::A_OVERRIDE_DAC_CODE, pdh_pkg::A_XTAL, pdh_pkg::A_LF_DLY,
    pdh_pkg::A_DAC_CLK, pdh_pkg::A_LOOP2_CTL, pdh_pkg::A_LOOP1_CTL,
    pdh_pkg::A_DIVIDERS, pdh_pkg::A_OSC_CAL, pdh_pkg::A_LOOP2_FB};
  localparam logic [31:0] RST_TAB [pdh_pkg::NREG] = '{
    pdh_pkg::RST_DAC_TRIP, pdh_pkg::RST_OVERRIDE_DAC_CODE, pdh_pkg::RST_XTAL,
    pdh_pkg::RST_LF_DLY, pdh_pkg::RST_DAC_CLK, pdh_pkg::RST_LOOP2_CTL,
    pdh_pkg::RST_LOOP1_CTL, pdh_pkg::RST_DIVIDERS, pdh_pkg::RST_OSC_CAL,
    pdh_pkg::RST_LOOP2_FB};

  logic [31:0]        regs_r [pdh_pkg::NREG];
  logic [31:0]        shift_r;
  logic [31:0]        rb_shift_r;
  logic               uw_clk_d_r;
  logic               uw_le_d_r;
  logic               clk_rise;
  logic               latch;
  logic [31:0]        rd_view;
  pdh_pkg::pdh_mode_e mode_r;
  logic [13:0]        lock1_cnt_r;
  logic [13:0]        lock2_cnt_r;
  logic [13:0]        exit_cnt_r;
  logic [9:0]         dac_div_cnt_r;
  logic               dac_tick;
  logic               trip_hit;
  logic               unlock1;
  logic               hold_enter;
  logic               exit_ok;
  logic [9:0]         hi_limit;
  logic [9:0]         lo_limit;

  // named views of the stored fields
  logic [5:0]  high_trip;
  logic [5:0]  low_trip;
  logic        rail_detect_enable;
  logic [9:0]  override_dac_code;
  logic        dac_override_enable;
  logic [13:0] holdover_exit_count;
  logic        force_holdover;
  logic [9:0]  dac_clk_divisor;
  logic [13:0] loop1_lock_count;
  logic [13:0] loop2_lock_count;

  assign high_trip           = regs_r[0][pdh_pkg::F_HTRIP +: 6];
  assign low_trip            = regs_r[0][pdh_pkg::F_LTRIP +: 6];
  assign rail_detect_enable  = regs_r[0][pdh_pkg::F_BIT5];
  assign override_dac_code   = regs_r[1][pdh_pkg::F_TOP10 +: 10];
  assign dac_override_enable = regs_r[1][pdh_pkg::F_OVR];
  assign holdover_exit_count = regs_r[1][pdh_pkg::F_CNT14 +: 14];
  assign force_holdover      = regs_r[1][pdh_pkg::F_BIT5];
  assign dac_clk_divisor     = regs_r[4][pdh_pkg::F_TOP10 +: 10];
  assign loop1_lock_count    = regs_r[4][pdh_pkg::F_CNT14 +: 14];
  assign loop2_lock_count    = regs_r[5][pdh_pkg::F_CNT14 +: 14];

  // ****************************************
  // three-wire port: shift on clock rise, commit on latch rise
  // ****************************************
  assign clk_rise = uw_clk & ~uw_clk_d_r;
  assign latch    = uw_le & ~uw_le_d_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      uw_clk_d_r <= 1'b0;
      uw_le_d_r  <= 1'b1;
    end else begin
      uw_clk_d_r <= uw_clk;
      uw_le_d_r  <= uw_le;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      shift_r <= 32'h0000_0000;
    end else if (clk_rise && !uw_le) begin
      shift_r <= {shift_r[30:0], uw_data};
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < pdh_pkg::NREG; gi++) begin : g_reg
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          regs_r[gi] <= RST_TAB[gi];
        end else if (latch && shift_r[4:0] == ADDR_TAB[gi]) begin
          regs_r[gi] <= {shift_r[31:5], 5'h00};
        end
      end
    end
  endgenerate

  // readback view; the dac register reports the live dac code
  always_comb begin
    rd_view = 32'h0000_0000;
    for (int i = 0; i < pdh_pkg::NREG; i++) begin
      if (shift_r[4:0] == ADDR_TAB[i]) begin
        rd_view = regs_r[i];
      end
    end
    if (shift_r[4:0] == pdh_pkg::A_OVERRIDE_DAC_CODE) begin
      rd_view[pdh_pkg::F_TOP10 +: 10] = dac_code;
    end
    rd_view[4:0] = shift_r[4:0];
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rb_shift_r <= 32'h0000_0000;
    end else if (latch) begin
      rb_shift_r <= rd_view;
    end else if (clk_rise && !uw_le) begin
      rb_shift_r <= {rb_shift_r[30:0], 1'b0};
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      uw_readback <= 1'b0;
    end else begin
      uw_readback <= latch ? rd_view[31] : rb_shift_r[31];
    end
  end

  // ****************************************
  // rail trip detection on the tuning code
  // ****************************************
  assign hi_limit = 10'h3FF - {high_trip, 4'h0};
  assign lo_limit = {low_trip, 4'h0};
  assign trip_hit = rail_detect_enable &&
                    (vtune_code >= hi_limit || vtune_code <= lo_limit);

  // ****************************************
  // loop1 lock detect
  // ****************************************
  assign unlock1 = !loop1_in_window || trip_hit;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lock1_cnt_r <= 14'h0000;
    end else if (unlock1) begin
      lock1_cnt_r <= 14'h0000;
    end else if (pd1_tick && lock1_cnt_r < loop1_lock_count) begin
      lock1_cnt_r <= lock1_cnt_r + 14'h0001;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      loop1_lock <= 1'b0;
    end else begin
      loop1_lock <= !unlock1 && lock1_cnt_r >= loop1_lock_count;
    end
  end

  // ****************************************
  // loop2 lock detect
  // ****************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lock2_cnt_r <= 14'h0000;
    end else if (!loop2_in_window) begin
      lock2_cnt_r <= 14'h0000;
    end else if (pd2_tick && lock2_cnt_r < loop2_lock_count) begin
      lock2_cnt_r <= lock2_cnt_r + 14'h0001;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      loop2_lock <= 1'b0;
    end else begin
      loop2_lock <= loop2_in_window && lock2_cnt_r >= loop2_lock_count;
    end
  end

  // ****************************************
  // holdover state
  // ****************************************
  assign hold_enter = force_holdover || trip_hit || (loop1_lock && unlock1);
  assign exit_ok    = !force_holdover && !trip_hit && loop1_in_window &&
                      exit_cnt_r >= holdover_exit_count;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      exit_cnt_r <= 14'h0000;
    end else if (mode_r != pdh_pkg::ST_HOLD || unlock1) begin
      exit_cnt_r <= 14'h0000;
    end else if (pd1_tick && exit_cnt_r < holdover_exit_count) begin
      exit_cnt_r <= exit_cnt_r + 14'h0001;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= pdh_pkg::ST_TRACK;
    end else begin
      unique case (mode_r)
        pdh_pkg::ST_TRACK: begin
          if (hold_enter) begin
            mode_r <= pdh_pkg::ST_HOLD;
          end
        end
        pdh_pkg::ST_HOLD: begin
          if (exit_ok) begin
            mode_r <= pdh_pkg::ST_TRACK;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      holdover <= 1'b0;
    end else begin
      holdover <= (mode_r == pdh_pkg::ST_HOLD) || force_holdover;
    end
  end

  // ****************************************
  // dac update divider and dac code
  // ****************************************
  assign dac_tick = pd1_tick && (dac_div_cnt_r + 10'h001 >= dac_clk_divisor);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dac_div_cnt_r <= 10'h000;
    end else if (dac_tick) begin
      dac_div_cnt_r <= 10'h000;
    end else if (pd1_tick) begin
      dac_div_cnt_r <= dac_div_cnt_r + 10'h001;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dac_code <= pdh_pkg::DAC_RST;
    end else if (dac_override_enable) begin
      dac_code <= override_dac_code;
    end else if (dac_tick && mode_r == pdh_pkg::ST_TRACK) begin
      dac_code <= vtune_code;
    end
  end

  // ****************************************
  // configuration outputs
  // ****************************************
  always_comb begin
    cfg.loop1_lock_window      = regs_r[3][7:6];
    cfg.loop2_lock_window      = regs_r[5][31:30];
    cfg.loop2_ref_doubler      = regs_r[5][29];
    cfg.loop2_pump_polarity    = regs_r[5][28];
    cfg.loop2_pump_gain        = regs_r[5][27:26];
    cfg.loop2_pump_tristate    = regs_r[5][5];
    cfg.loop1_pump_polarity    = regs_r[6][28];
    cfg.loop1_pump_gain        = regs_r[6][27:26];
    cfg.loop1_pump_tristate    = regs_r[6][5];
    cfg.input1_prediv          = regs_r[6][23:22];
    cfg.input0_prediv          = regs_r[6][21:20];
    cfg.loop1_ref_divider      = regs_r[6][19:6];
    cfg.loop2_ref_divider      = regs_r[7][31:20];
    cfg.loop1_feedback_divider = regs_r[7][19:6];
    cfg.osc_input_range        = regs_r[8][26:24];
    cfg.loop2_fast_detector    = regs_r[8][23];
    cfg.loop2_cal_divider      = regs_r[8][pdh_pkg::F_N18 +: 18];
    cfg.loop2_prescaler        = regs_r[9][26:24];
    cfg.loop2_feedback_divider = regs_r[9][pdh_pkg::F_N18 +: 18];
  end

endmodule

// ===== pdh_bank_props.sv
// pdh_bank_props: port assertions for the loop configuration bank.
// assumes: one clock domain; bound to every pdh_bank instance.
`timescale 1ns/10ps
module pdh_bank_props (
  input wire logic              mclk,
  input wire logic              nrst,
  input wire logic              uw_clk,
  input wire logic              uw_data,
  input wire logic              uw_le,
  input wire logic              pd1_tick,
  input wire logic              pd2_tick,
  input wire logic              loop1_in_window,
  input wire logic              loop2_in_window,
  input wire logic [9:0]        vtune_code,
  input wire logic              uw_readback,
  input wire logic              holdover,
  input wire logic              loop1_lock,
  input wire logic              loop2_lock,
  input wire logic [9:0]        dac_code,
  input wire pdh_pkg::pdh_cfg_s cfg
);
  logic [2:0] le_h;
  logic       le_rise;
  // ****
  // recent latch rise
  // ****
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      le_h <= 3'h7;
    end else begin
      le_h <= {le_h[1:0], uw_le};
    end
  end
  assign le_rise = (le_h[0] && !le_h[1]) || (le_h[1] && !le_h[2]);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  reset_fields_a: assert property (
    !$past(nrst) |-> cfg.loop1_ref_divider == 14'h0060 && cfg.loop2_ref_divider == 12'h004
    && cfg.loop1_feedback_divider == 14'h00C0 && cfg.loop2_cal_divider == 18'h00030
    && cfg.loop2_prescaler == 3'h2 && cfg.loop2_feedback_divider == 18'h00030)
    else $error("divider field wrong after reset");
  reset_modes_a: assert property (
    !$past(nrst) |-> cfg.loop1_lock_window == 2'h3 && !cfg.loop2_ref_doubler
    && !cfg.loop2_pump_polarity && cfg.loop2_pump_gain == 2'h3 && !cfg.loop2_pump_tristate
    && cfg.loop1_pump_polarity && cfg.loop1_pump_gain == 2'h0 && cfg.input1_prediv == 2'h0
    && cfg.input0_prediv == 2'h0 && cfg.loop2_fast_detector)
    else $error("mode field wrong after reset");
  cfg_write_a: assert property (!$stable(cfg) |-> le_rise)
    else $error("configuration changed without a frame");
  dac_move_a: assert property (
    !$stable(dac_code) |-> $past(pd1_tick) || $past(pd1_tick, 2) || le_rise)
    else $error("dac code changed without cause");
  lock1_rise_a: assert property ($rose(loop1_lock) |-> $past(loop1_in_window))
    else $error("loop1 lock rose out of window");
  lock2_rise_a: assert property (
    $rose(loop2_lock) |-> $past(loop2_in_window) && ($past(pd2_tick) || $past(pd2_tick, 2)))
    else $error("loop2 lock rose without a tick in window");
  hold_exit_a: assert property ($fell(holdover) |-> $past(loop1_in_window, 2))
    else $error("holdover left out of window");
  hold_enter_a: assert property ($fell(loop1_lock) |-> ##[0:2] holdover)
    else $error("no holdover after loop1 unlock");
endmodule
bind pdh_bank pdh_bank_props u_props (.mclk(mclk), .nrst(nrst), .uw_clk(uw_clk),
  .uw_data(uw_data), .uw_le(uw_le), .pd1_tick(pd1_tick), .pd2_tick(pd2_tick),
  .loop1_in_window(loop1_in_window), .loop2_in_window(loop2_in_window),
  .vtune_code(vtune_code), .uw_readback(uw_readback), .holdover(holdover),
  .loop1_lock(loop1_lock), .loop2_lock(loop2_lock), .dac_code(dac_code), .cfg(cfg));

// ===== pdh_host.sv
// pdh_host: host model sending frames on the three-wire port.
// assumes: mclk from the bench; readback taken between clock edges.
`timescale 1ns/10ps
module pdh_host (
  input  wire logic mclk,
  input  wire logic uw_readback,
  output logic      uw_clk,
  output logic      uw_data,
  output logic      uw_le
);
  initial begin
    uw_clk  = 1'b0;
    uw_data = 1'b0;
    uw_le   = 1'b1;
  end
  // ****
  // one frame, msb first, readback collected meanwhile
  // ****
  task automatic xfer(input logic [31:0] w, output logic [31:0] rd);
    @(posedge mclk);
    uw_le <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      @(posedge mclk);
      uw_clk  <= 1'b0;
      uw_data <= w[i];
      @(posedge mclk);
      uw_clk <= 1'b1;
      #10 rd[i] = uw_readback;
    end
    @(posedge mclk);
    uw_clk  <= 1'b0;
    uw_data <= ~w[0];
    @(posedge mclk);
    uw_le <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
  endtask
endmodule

// ===== test_pdh_bank.sv
// test_pdh_bank: frame level tests of the loop configuration bank.
// assumes: pdh_host drives the port; ticks and window levels come from here.
`timescale 1ns/10ps
module test_pdh_bank;
  logic              mclk, nrst, uw_clk, uw_data, uw_le, uw_readback;
  logic              pd1_tick, pd2_tick, win1, win2, holdover, loop1_lock, loop2_lock;
  logic [9:0]        vtune_code, dac_code;
  logic [31:0]       rd, w;
  pdh_pkg::pdh_cfg_s cfg, exp;
  int                errors, tests_run, n;
  int                cyc = 0;
  pdh_bank DUT (.mclk(mclk), .nrst(nrst), .uw_clk(uw_clk), .uw_data(uw_data), .uw_le(uw_le),
    .pd1_tick(pd1_tick), .pd2_tick(pd2_tick), .loop1_in_window(win1),
    .loop2_in_window(win2), .vtune_code(vtune_code), .uw_readback(uw_readback),
    .holdover(holdover), .loop1_lock(loop1_lock), .loop2_lock(loop2_lock),
    .dac_code(dac_code), .cfg(cfg));
  pdh_host host (.mclk(mclk), .uw_readback(uw_readback), .uw_clk(uw_clk),
    .uw_data(uw_data), .uw_le(uw_le));
  always #10 mclk = ~mclk;
  // ****
  // helpers
  // ****
  task automatic finish_test();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [127:0] got, input logic [127:0] want);
    tests_run++;
    if (got !== want) begin
      errors++;
      $display("Error %s expected %0h seen %0h", nm, want, got);
    end
  endtask
  task automatic wr(input logic [31:0] v);
    host.xfer(v, rd);
  endtask
  function automatic logic [31:0] man(input logic [9:0] c, input logic e, input logic f);
    return {c, 1'b0, e, 14'h0002, f, 5'h0F};
  endfunction
  task automatic drv(input logic [9:0] v, input logic w1, input logic w2);
    @(posedge mclk);
    vtune_code <= v;
    win1 <= w1;
    win2 <= w2;
    #1;
  endtask
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge mclk);
      pd1_tick <= 1'b1;
      pd2_tick <= 1'b1;
      @(posedge mclk);
      pd1_tick <= 1'b0;
      pd2_tick <= 1'b0;
      repeat (2) @(posedge mclk);
    end
    #1;
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    pd1_tick = 1'b0;
    pd2_tick = 1'b0;
    win1 = 1'b0;
    win2 = 1'b0;
    vtune_code = 10'h200;
    errors = 0;
    tests_run = 0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    #1;
    exp = '{2'h3, 2'h0, 1'b0, 1'b0, 2'h3, 1'b0, 1'b1, 2'h0, 1'b0, 2'h0, 2'h0, 14'h0060,
            12'h004, 14'h00C0, 3'h7, 1'b1, 18'h00030, 3'h2, 18'h00030};
    chk("cfg_reset", cfg, exp);
    chk("dac_reset", dac_code, 10'h200);
    wr({10'h001, 2'h0, 14'h0003, 6'h19});
    wr(man(10'h200, 1'b0, 1'b0));
    drv(10'h1A5, 1'b1, 1'b0);
    tick(2);
    chk("lock1_early", loop1_lock, 1'b0);
    tick(1);
    chk("lock1_set", loop1_lock, 1'b1);
    tick(4);
    chk("hold_left", holdover, 1'b0);
    chk("dac_track", dac_code, 10'h1A5);
    wr(man(10'h200, 1'b0, 1'b1));
    chk("hold_forced", holdover, 1'b1);
    wr(man(10'h200, 1'b0, 1'b0));
    tick(1);
    chk("hold_wait", holdover, 1'b1);
    tick(2);
    chk("hold_exit", holdover, 1'b0);
    wr(man(10'h155, 1'b1, 1'b0));
    chk("dac_manual", dac_code, 10'h155);
    wr(man(10'h0AA, 1'b0, 1'b0));
    tick(1);
    wr(man(10'h0AA, 1'b0, 1'b0));
    host.xfer({27'h0, 5'h01}, rd);
    chk("dac_readback", rd[31:22], 10'h1A5);
    wr({10'h003, 2'h0, 14'h0003, 6'h19});
    n = 0;
    for (int i = 0; i < 6; i++) begin
      drv(10'(10'h100 + i), 1'b1, 1'b0);
      tick(1);
      if (dac_code === 10'(10'h100 + i)) n++;
    end
    chk("dac_divide", n, 2);
    wr({26'h0, 1'b1, 5'h0E});
    drv(10'h3FE, 1'b1, 1'b0);
    tick(1);
    chk("rail_near", holdover, 1'b0);
    for (int i = 0; i < 2; i++) begin
      drv(i ? 10'h000 : 10'h3FF, 1'b1, 1'b0);
      tick(1);
      chk("rail_hold", holdover, 1'b1);
      chk("rail_unlock", loop1_lock, 1'b0);
      drv(10'h155, 1'b1, 1'b0);
      tick(12);
      chk("rail_clear", holdover, 1'b0);
    end
    wr({26'h0, 1'b0, 5'h0E});
    drv(10'h3FF, 1'b1, 1'b0);
    tick(1);
    chk("rail_off", holdover, 1'b0);
    wr({2'h2, 1'b1, 1'b1, 2'h1, 6'h0, 14'h0004, 1'b1, 5'h1A});
    drv(10'h155, 1'b1, 1'b1);
    tick(3);
    chk("lock2_early", loop2_lock, 1'b0);
    tick(1);
    chk("lock2_set", loop2_lock, 1'b1);
    wr({24'h0, 2'h1, 6'h18});
    wr({12'hFFF, 14'h3FFF, 6'h1C});
    wr({5'h0, 3'h7, 1'b0, 18'h3FFFF, 5'h1E});
    wr({5'h0, 3'h5, 1'b0, 18'h2A5A5, 5'h1D});
    w = {3'h0, 1'b0, 2'h2, 2'h0, 2'h3, 2'h2, 14'h0001, 1'b1, 5'h1B};
    // a frame reads back the register the previous frame addressed, as it stood before that frame's write
    wr(w);
    wr(w);
    host.xfer({27'h0, 5'h01}, rd);
    chk("readback", rd[31:5], w[31:5]);
    exp = '{2'h1, 2'h2, 1'b1, 1'b1, 2'h1, 1'b1, 1'b0, 2'h2, 1'b1, 2'h3, 2'h2, 14'h0001,
            12'hFFF, 14'h3FFF, 3'h5, 1'b0, 18'h2A5A5, 3'h7, 18'h3FFFF};
    chk("cfg_written", cfg, exp);
    finish_test();
  end
endmodule
